// File: logic/ppbr_pkg.sv
// shared constants and types of the port parameter backup and restore block
package ppbr_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_INSPECT   = 16'h28aa;
  localparam logic [15:0] IDX_ACTIVATE  = 16'h28ab;
  localparam logic [15:0] IDX_DL_ENABLE = 16'h28ac;
  localparam logic [15:0] IDX_UL_ENABLE = 16'h28ad;
  localparam logic [15:0] IDX_STATUS    = 16'h28b0;

  // reset values
  localparam logic [7:0] RST_INSPECT   = 8'h00;
  localparam logic [7:0] RST_ACTIVATE  = 8'h00;
  localparam logic [7:0] RST_DL_ENABLE = 8'h00;
  localparam logic [7:0] RST_UL_ENABLE = 8'h00;

  // activation setting encodings
  localparam logic [7:0] ACT_INACTIVE_KEEP  = 8'h00;
  localparam logic [7:0] ACT_ACTIVE         = 8'h01;
  localparam logic [7:0] ACT_INACTIVE_ERASE = 8'h02;

  // validation level encodings
  localparam logic [7:0] LVL_NO_CHECK            = 8'h00;
  localparam logic [7:0] LVL_CHECK_TYPE          = 8'h01;
  localparam logic [7:0] LVL_CHECK_FULL_IDENTITY = 8'h02;

  // device command that forces an upload into the master
  localparam logic [15:0] CMD_INDEX        = 16'h0002;
  localparam logic [7:0]  CMD_FORCE_UPLOAD = 8'h05;

  // parameter set geometry
  localparam int unsigned PAR_WORDS = 4;
  localparam int unsigned PAR_IW    = 2;
  localparam logic [1:0]  PAR_LAST  = 2'h3;

  // status register bit positions
  localparam int unsigned ST_VALID    = 0;
  localparam int unsigned ST_BUSY     = 1;
  localparam int unsigned ST_STATE_LO = 2;
  localparam int unsigned ST_MISMATCH = 4;
  localparam int unsigned ST_UL_DONE  = 5;
  localparam int unsigned ST_DL_DONE  = 6;
  localparam int unsigned ST_SKIPPED  = 7;

  typedef enum logic [1:0] {
    PPBR_IDLE    = 2'b00,
    PPBR_UPLOAD  = 2'b01,
    PPBR_COMPARE = 2'b10,
    PPBR_RESTORE = 2'b11
  } ppbr_state_t;
endpackage

// File: logic/ppbr_store.sv
// flip-flop storage of one port's parameter set with its valid flag
`timescale 1ns/1ps
module ppbr_store (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_idx,
  input  wire logic [31:0] wr_data,
  input  wire logic        erase,
  input  wire logic        clr_valid,
  input  wire logic        set_valid,
  input  wire logic [1:0]  rd_idx,
  output logic [31:0]      rd_data,
  output logic             valid
);
  logic [31:0] mem_q [ppbr_pkg::PAR_WORDS];

  ////////////////////////////////////////////////////////////////////////
  // one word per entry; erase wipes contents so nothing stale survives
  for (genvar i = 0; i < ppbr_pkg::PAR_WORDS; i++) begin : g_word
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem_q[i] <= 32'h0000_0000;
      end else if (ce) begin
        if (erase) begin
          mem_q[i] <= 32'h0000_0000;
        end else if (wr_en && wr_idx == 2'(i)) begin
          mem_q[i] <= wr_data;
        end
      end
    end
  end

  // valid flag: erase and clear win, set only after a complete upload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid <= 1'b0;
    end else if (ce) begin
      if (erase || clr_valid) begin
        valid <= 1'b0;
      end else if (set_valid) begin
        valid <= 1'b1;
      end
    end
  end

  assign rd_data = mem_q[rd_idx];
endmodule

// File: logic/ppbr_top.sv
// parameter backup and restore controller for one master port, apb slave
// Notes on behaviour
// - activation 0 keep, 1 active, 2 erase
// - inactive-keep: no transfers, stored set retained
// - inactive-erase: stop transfers, delete stored set
// - transfers need vendor and device identity check
// - restore needs download permit, backup upload permit
// - device storage locks skip backup and restore
// - no valid stored set: upload if permitted
// - device command 0x05 at 0x0002 forces upload
// - new connection compares stored set against device
// - any mismatch with permit writes stored set
// - validation level 0 none, 1 type, 2 full
`timescale 1ns/1ps
module ppbr_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dev_connect,
  input  wire logic        dev_ds_lock,
  input  wire logic        dev_par_lock,
  input  wire logic        dev_cmd_valid,
  input  wire logic [15:0] dev_cmd_index,
  input  wire logic [7:0]  dev_cmd_value,
  output logic             rd_req,
  output logic [1:0]       rd_idx,
  input  wire logic        rd_ack,
  input  wire logic [31:0] rd_data,
  output logic             wr_req,
  output logic [1:0]       wr_idx,
  output logic [31:0]      wr_data,
  input  wire logic        wr_ack
);
  logic [7:0]  inspect_q;
  logic [7:0]  activate_q;
  logic [7:0]  dl_enable_q;
  logic [7:0]  ul_enable_q;
  logic        captured_q;
  logic        conn_pend_q;
  logic        force_pend_q;
  logic        mismatch_q;
  logic        ul_done_q;
  logic        dl_done_q;
  logic        skipped_q;
  logic [1:0]  idx_q;
  ppbr_pkg::ppbr_state_t state_q;
  ppbr_pkg::ppbr_state_t state_d;

  logic [15:0] reg_idx;
  logic        addr_ok;
  logic        bus_wr;
  logic [31:0] rd_mux;
  logic [7:0]  status;
  logic        act_on;
  logic        act_erase;
  logic        lvl_ok;
  logic        locked;
  logic        gate;
  logic        may_ul;
  logic        may_dl;
  logic        force_cmd;
  logic        start_ul;
  logic        start_cmp;
  logic        last_word;
  logic        store_valid;
  logic [31:0] store_rdata;
  logic        store_wr;
  logic        store_clr;
  logic        store_set;

  ////////////////////////////////////////////////////////////////////////
  // apb decode: index is the word address, low two bits must be zero
  assign reg_idx = {2'b00, paddr[15:2]};
  assign addr_ok = (paddr[1:0] == 2'b00) &&
                   (reg_idx == ppbr_pkg::IDX_INSPECT ||
                    reg_idx == ppbr_pkg::IDX_ACTIVATE ||
                    reg_idx == ppbr_pkg::IDX_DL_ENABLE ||
                    reg_idx == ppbr_pkg::IDX_UL_ENABLE ||
                    reg_idx == ppbr_pkg::IDX_STATUS);

  // ready comes one cycle after capture, so a frozen clock enable stalls
  assign pready = ce && captured_q;
  assign bus_wr = psel && penable && pwrite && pready && addr_ok;

  // read mux; narrow registers sit in the low byte, upper bits zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_idx)
      ppbr_pkg::IDX_INSPECT:   rd_mux[7:0] = inspect_q;
      ppbr_pkg::IDX_ACTIVATE:  rd_mux[7:0] = activate_q;
      ppbr_pkg::IDX_DL_ENABLE: rd_mux[7:0] = dl_enable_q;
      ppbr_pkg::IDX_UL_ENABLE: rd_mux[7:0] = ul_enable_q;
      ppbr_pkg::IDX_STATUS:    rd_mux[7:0] = status;
      default:                 rd_mux = 32'h0000_0000;
    endcase
  end

  // capture read data and error in the first cycle of each transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      captured_q <= 1'b0;
      prdata     <= 32'h0000_0000;
      pslverr    <= 1'b0;
    end else if (ce) begin
      captured_q <= psel && !(penable && captured_q);
      if (psel && !captured_q) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= !addr_ok;
      end
    end
  end

  // software registers; all bits stored, codes outside the table act inert
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inspect_q   <= ppbr_pkg::RST_INSPECT;
      activate_q  <= ppbr_pkg::RST_ACTIVATE;
      dl_enable_q <= ppbr_pkg::RST_DL_ENABLE;
      ul_enable_q <= ppbr_pkg::RST_UL_ENABLE;
    end else if (ce && bus_wr) begin
      case (reg_idx)
        ppbr_pkg::IDX_INSPECT:   inspect_q   <= pwdata[7:0];
        ppbr_pkg::IDX_ACTIVATE:  activate_q  <= pwdata[7:0];
        ppbr_pkg::IDX_DL_ENABLE: dl_enable_q <= pwdata[7:0];
        ppbr_pkg::IDX_UL_ENABLE: ul_enable_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // qualification of the storage mechanism
  assign act_on    = (activate_q == ppbr_pkg::ACT_ACTIVE);
  assign act_erase = (activate_q == ppbr_pkg::ACT_INACTIVE_ERASE);
  // level 1 or 2 both check vendor and device identity
  assign lvl_ok = (inspect_q == ppbr_pkg::LVL_CHECK_TYPE) ||
                  (inspect_q == ppbr_pkg::LVL_CHECK_FULL_IDENTITY);
  assign locked = dev_ds_lock || dev_par_lock;
  assign gate   = act_on && lvl_ok && !locked;
  assign may_ul = gate && (ul_enable_q != 8'h00);
  assign may_dl = gate && (dl_enable_q != 8'h00);

  assign force_cmd = dev_cmd_valid && dev_cmd_index == ppbr_pkg::CMD_INDEX &&
                     dev_cmd_value == ppbr_pkg::CMD_FORCE_UPLOAD;

  // a connection decides first; only one direction per event
  assign start_ul  = (state_q == ppbr_pkg::PPBR_IDLE) &&
                     ((conn_pend_q && !store_valid) ||
                      (!conn_pend_q && force_pend_q)) && may_ul;
  assign start_cmp = (state_q == ppbr_pkg::PPBR_IDLE) && conn_pend_q &&
                     store_valid && gate;
  assign last_word = (idx_q == ppbr_pkg::PAR_LAST);

  // pending events; a new event in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conn_pend_q  <= 1'b0;
      force_pend_q <= 1'b0;
    end else if (ce) begin
      if (dev_connect) begin
        conn_pend_q <= 1'b1;
      end else if (state_q == ppbr_pkg::PPBR_IDLE) begin
        conn_pend_q <= 1'b0;
      end
      if (force_cmd) begin
        force_pend_q <= 1'b1;
      end else if (state_q == ppbr_pkg::PPBR_IDLE && !conn_pend_q) begin
        force_pend_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transfer sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ppbr_pkg::PPBR_IDLE: begin
        if (start_ul) begin
          state_d = ppbr_pkg::PPBR_UPLOAD;
        end else if (start_cmp) begin
          state_d = ppbr_pkg::PPBR_COMPARE;
        end
      end
      ppbr_pkg::PPBR_UPLOAD: begin
        if (!may_ul) begin
          state_d = ppbr_pkg::PPBR_IDLE;
        end else if (rd_ack && last_word) begin
          state_d = ppbr_pkg::PPBR_IDLE;
        end
      end
      ppbr_pkg::PPBR_COMPARE: begin
        if (!gate) begin
          state_d = ppbr_pkg::PPBR_IDLE;
        end else if (rd_ack && last_word) begin
          // any differing word, now or earlier, triggers a restore when download is permitted
          if ((mismatch_q || rd_data != store_rdata) && may_dl) begin
            state_d = ppbr_pkg::PPBR_RESTORE;
          end else begin
            state_d = ppbr_pkg::PPBR_IDLE;
          end
        end
      end
      ppbr_pkg::PPBR_RESTORE: begin
        if (!may_dl) begin
          state_d = ppbr_pkg::PPBR_IDLE;
        end else if (wr_ack && last_word) begin
          state_d = ppbr_pkg::PPBR_IDLE;
        end
      end
      default: state_d = ppbr_pkg::PPBR_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ppbr_pkg::PPBR_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // word index: restart at zero on every state change, step on each ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q <= 2'h0;
    end else if (ce) begin
      if (state_d != state_q) begin
        idx_q <= 2'h0;
      end else if ((rd_req && rd_ack) || (wr_req && wr_ack)) begin
        idx_q <= idx_q + 2'h1;
      end
    end
  end

  // result flags, cleared when a new transfer begins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mismatch_q <= 1'b0;
      ul_done_q  <= 1'b0;
      dl_done_q  <= 1'b0;
      skipped_q  <= 1'b0;
    end else if (ce) begin
      if (start_ul || start_cmp) begin
        mismatch_q <= 1'b0;
        ul_done_q  <= 1'b0;
        dl_done_q  <= 1'b0;
        skipped_q  <= 1'b0;
      end else begin
        if (state_q == ppbr_pkg::PPBR_COMPARE && rd_ack && rd_data != store_rdata) begin
          mismatch_q <= 1'b1;
        end
        if (state_q == ppbr_pkg::PPBR_UPLOAD && rd_ack && last_word && may_ul) begin
          ul_done_q <= 1'b1;
        end
        if (state_q == ppbr_pkg::PPBR_RESTORE && wr_ack && last_word && may_dl) begin
          dl_done_q <= 1'b1;
        end
        // an event dropped because the mechanism was not allowed to run
        if (state_q == ppbr_pkg::PPBR_IDLE && (conn_pend_q || force_pend_q)) begin
          skipped_q <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // store control: upload invalidates first so a torn set is never used
  assign store_wr  = (state_q == ppbr_pkg::PPBR_UPLOAD) && rd_ack && may_ul;
  assign store_clr = start_ul;
  assign store_set = store_wr && last_word;

  ppbr_store u_store (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .wr_en     (store_wr),
    .wr_idx    (idx_q),
    .wr_data   (rd_data),
    .erase     (act_erase),
    .clr_valid (store_clr),
    .set_valid (store_set),
    .rd_idx    (idx_q),
    .rd_data   (store_rdata),
    .valid     (store_valid)
  );

  // device side requests; held until the matching ack, or dropped when a lost permit aborts the transfer to idle
  assign rd_req  = (state_q == ppbr_pkg::PPBR_UPLOAD) ||
                   (state_q == ppbr_pkg::PPBR_COMPARE);
  assign rd_idx  = idx_q;
  assign wr_req  = (state_q == ppbr_pkg::PPBR_RESTORE);
  assign wr_idx  = idx_q;
  assign wr_data = store_rdata;

  // status word seen by software
  always_comb begin
    status = 8'h00;
    status[ppbr_pkg::ST_VALID]    = store_valid;
    status[ppbr_pkg::ST_BUSY]     = (state_q != ppbr_pkg::PPBR_IDLE);
    status[ppbr_pkg::ST_STATE_LO +: 2] = state_q;
    status[ppbr_pkg::ST_MISMATCH] = mismatch_q;
    status[ppbr_pkg::ST_UL_DONE]  = ul_done_q;
    status[ppbr_pkg::ST_DL_DONE]  = dl_done_q;
    status[ppbr_pkg::ST_SKIPPED]  = skipped_q;
  end
endmodule

// File: test/ppbr_monitor.sv
// assertion checker on the ports of the backup and restore controller
`timescale 1ns/1ps
module ppbr_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        dev_connect,
  input wire logic        dev_ds_lock,
  input wire logic        dev_par_lock,
  input wire logic        rd_req,
  input wire logic [1:0]  rd_idx,
  input wire logic        rd_ack,
  input wire logic        wr_req,
  input wire logic        wr_ack
);
  logic [7:0] act_q;
  logic [7:0] lvl_q;
  logic [7:0] dl_q;
  logic [7:0] ul_q;
  logic       wr_ok;
  logic       gate;
  ////////////////////////////////////////////////////////////////////////////////
  // shadow copies of the settings, taken only from writes that completed cleanly
  assign wr_ok = psel && penable && pready && pwrite && !pslverr && paddr[1:0] == 2'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= 8'h00;
      lvl_q <= 8'h00;
      dl_q  <= 8'h00;
      ul_q  <= 8'h00;
    end else if (wr_ok) begin
      if (paddr[15:2] == ppbr_pkg::IDX_ACTIVATE[13:0]) act_q <= pwdata[7:0];
      if (paddr[15:2] == ppbr_pkg::IDX_INSPECT[13:0]) lvl_q <= pwdata[7:0];
      if (paddr[15:2] == ppbr_pkg::IDX_DL_ENABLE[13:0]) dl_q <= pwdata[7:0];
      if (paddr[15:2] == ppbr_pkg::IDX_UL_ENABLE[13:0]) ul_q <= pwdata[7:0];
    end
  end
  assign gate = act_q == 8'h01 && lvl_q inside {8'h01, 8'h02} && !dev_ds_lock && !dev_par_lock;
  ////////////////////////////////////////////////////////////////////////////////
  // three cycles of settling allow for the abort after a setting changes
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_quiet;
    (!rd_req && !wr_req) [*3];
  endsequence
  sequence s_go;
    dev_connect && gate && ul_q != 8'h00;
  endsequence
  a_idle_inactive: assert property ((act_q != 8'h01) [*3] |-> !rd_req && !wr_req)
    else $error("transfer while storage inactive");
  a_no_check: assert property ((lvl_q == 8'h00) [*3] |-> !rd_req && !wr_req)
    else $error("transfer without identity check");
  a_lock_skip: assert property ((dev_ds_lock || dev_par_lock) [*3] |-> !rd_req && !wr_req)
    else $error("transfer while device locked");
  a_restore_permit: assert property ((dl_q == 8'h00) [*3] |-> !wr_req)
    else $error("restore without permit");
  a_one_dir: assert property (!(rd_req && wr_req))
    else $error("read and write requested together");
  a_read_order: assert property (rd_req && rd_ack |=> !rd_req || rd_idx == $past(rd_idx) + 2'h1)
    else $error("read word order broken");
  a_conn_start: assert property (s_quiet ##1 s_go |-> ##[1:3] (rd_req && rd_idx == 2'h0))
    else $error("connection did not start a read");
  a_apb_ready: assert property (psel && !penable && ce |=> pready)
    else $error("register access not answered");
  a_unmapped_err: assert property (psel && penable && pready && paddr[15:2] == 14'h28ae |-> pslverr)
    else $error("unmapped access without error");
endmodule

// File: test/ppbr_field_dev.sv
// behavioural model of the connected field device holding its parameter set
`timescale 1ns/1ps
module ppbr_field_dev (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        slow,
  input wire logic        rd_req,
  input wire logic [1:0]  rd_idx,
  output logic            rd_ack,
  output logic [31:0]     rd_data,
  input wire logic        wr_req,
  input wire logic [1:0]  wr_idx,
  input wire logic [31:0] wr_data,
  output logic            wr_ack
);
  logic [31:0] par [4];
  logic [1:0]  dly;
  int          n_rd;
  int          n_wr;
  // one word per request, a gap after each ack; slow mode waits three extra cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ack  <= 1'h0;
      wr_ack  <= 1'h0;
      rd_data <= 32'h0;
      dly     <= 2'h0;
      n_rd    <= 0;
      n_wr    <= 0;
    end else begin
      rd_ack  <= 1'h0;
      wr_ack  <= 1'h0;
      rd_data <= ~rd_data; // data not valid outside an ack, so keep it moving
      if ((rd_req || wr_req) && !rd_ack && !wr_ack) begin
        if (slow && dly != 2'h3) begin
          dly <= dly + 2'h1;
        end else begin
          dly <= 2'h0;
          if (rd_req) begin
            rd_ack  <= 1'h1;
            rd_data <= par[rd_idx];
            n_rd    <= n_rd + 1;
          end else begin
            wr_ack      <= 1'h1;
            par[wr_idx] <= wr_data;
            n_wr        <= n_wr + 1;
          end
        end
      end
    end
  end
endmodule

// File: test/tb_top.sv
// self-checking bench of the backup and restore controller
`timescale 1ns/1ps
module tb_top;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, e, slow;
  logic        dev_connect, dev_ds_lock, dev_par_lock, dev_cmd_valid;
  logic        rd_req, rd_ack, wr_req, wr_ack;
  logic [1:0]  rd_idx, wr_idx;
  logic [7:0]  dev_cmd_value;
  logic [15:0] paddr, dev_cmd_index;
  logic [31:0] pwdata, prdata, rd_data, wr_data, r;
  logic [15:0] regs [5];
  int          n_mismatch, num_checks, cyc;
  ppbr_top i_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .dev_connect, .dev_ds_lock, .dev_par_lock, .dev_cmd_valid,
    .dev_cmd_index, .dev_cmd_value, .rd_req, .rd_idx, .rd_ack, .rd_data, .wr_req, .wr_idx,
    .wr_data, .wr_ack);
  ppbr_field_dev i_dev (.pclk, .presetn, .slow, .rd_req, .rd_idx, .rd_ack, .rd_data, .wr_req,
    .wr_idx, .wr_data, .wr_ack);
  ////////////////////////////////////////////////////////////////////////////////
  always #25 pclk = ~pclk;
  // a hung handshake ends the run here
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      n_mismatch++;
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one apb transfer; an idle cycle after it keeps each strobe to one change per edge
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {idx[13:0], 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // no cycle count assumed here; only the bench timeout ends a hung access
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [15:0] idx, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'h0, idx, 32'h0);
    check(r & mask, exp);
  endtask
  // fire a connection or device command, wait until idle, compare word counts
  task automatic run(input logic cmd, input logic [7:0] val, input int drd, input int dwr);
    int rd0, wr0;
    rd0 = i_dev.n_rd;
    wr0 = i_dev.n_wr;
    if (cmd) dev_cmd_valid <= 1'h1;
    else dev_connect <= 1'h1;
    dev_cmd_value <= val;
    @(posedge pclk);
    dev_cmd_valid <= 1'h0;
    dev_connect <= 1'h0;
    repeat (3) @(posedge pclk);
    do apb(1'h0, ppbr_pkg::IDX_STATUS, 32'h0); while (r[ppbr_pkg::ST_BUSY] !== 1'h0);
    check(32'(i_dev.n_rd - rd0), 32'(drd));
    check(32'(i_dev.n_wr - wr0), 32'(dwr));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {pclk, presetn, psel, penable, pwrite, dev_connect, dev_ds_lock, dev_par_lock} = 8'h00;
    {dev_cmd_valid, slow, paddr, pwdata, dev_cmd_value, n_mismatch, num_checks, cyc} = '0;
    ce = 1'h1;
    dev_cmd_index = ppbr_pkg::CMD_INDEX;
    regs = '{ppbr_pkg::IDX_INSPECT, ppbr_pkg::IDX_ACTIVATE, ppbr_pkg::IDX_DL_ENABLE,
             ppbr_pkg::IDX_UL_ENABLE, ppbr_pkg::IDX_STATUS};
    for (int i = 0; i < 4; i++) i_dev.par[i] = 32'ha5a50000 | 32'(i);
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) rchk(regs[i], 32'hffffffff, 32'h0);
    apb(1'h0, 16'h28ae, 32'h0);
    check({31'h0, e}, 32'h1);
    apb(1'h1, ppbr_pkg::IDX_STATUS, 32'hff);
    rchk(ppbr_pkg::IDX_STATUS, 32'hffffffff, 32'h0);
    for (int i = 0; i < 3; i++) begin
      apb(1'h1, ppbr_pkg::IDX_ACTIVATE, 32'(i));
      rchk(ppbr_pkg::IDX_ACTIVATE, 32'hffffffff, 32'(i));
    end
    apb(1'h1, ppbr_pkg::IDX_ACTIVATE, 32'h1);
    apb(1'h1, ppbr_pkg::IDX_UL_ENABLE, 32'h1);
    apb(1'h1, ppbr_pkg::IDX_DL_ENABLE, 32'h1);
    run(1'h0, 8'h00, 0, 0);
    apb(1'h1, ppbr_pkg::IDX_INSPECT, 32'h2);
    run(1'h0, 8'h00, 4, 0);
    rchk(ppbr_pkg::IDX_STATUS, 32'h21, 32'h21);
    i_dev.par[2] = 32'h0;
    slow <= 1'h1;
    apb(1'h1, ppbr_pkg::IDX_INSPECT, 32'h1);
    run(1'h0, 8'h00, 4, 4);
    check(i_dev.par[2], 32'ha5a50002);
    rchk(ppbr_pkg::IDX_STATUS, 32'h50, 32'h50);
    run(1'h0, 8'h00, 4, 0);
    for (int k = 0; k < 2; k++) begin
      dev_ds_lock <= (k == 0);
      dev_par_lock <= (k == 1);
      i_dev.par[1] = 32'h1;
      run(1'h0, 8'h00, 0, 0);
      rchk(ppbr_pkg::IDX_STATUS, 32'h80, 32'h80);
    end
    dev_ds_lock <= 1'h0;
    dev_par_lock <= 1'h0;
    apb(1'h1, ppbr_pkg::IDX_DL_ENABLE, 32'h0);
    run(1'h0, 8'h00, 4, 0);
    run(1'h1, 8'h04, 0, 0);
    run(1'h1, ppbr_pkg::CMD_FORCE_UPLOAD, 4, 0);
    apb(1'h1, ppbr_pkg::IDX_UL_ENABLE, 32'h0);
    run(1'h1, ppbr_pkg::CMD_FORCE_UPLOAD, 0, 0);
    apb(1'h1, ppbr_pkg::IDX_ACTIVATE, 32'h0);
    run(1'h0, 8'h00, 0, 0);
    rchk(ppbr_pkg::IDX_STATUS, 32'h1, 32'h1);
    apb(1'h1, ppbr_pkg::IDX_ACTIVATE, 32'h2);
    rchk(ppbr_pkg::IDX_STATUS, 32'h1, 32'h0);
    apb(1'h1, ppbr_pkg::IDX_ACTIVATE, 32'h1);
    run(1'h0, 8'h00, 0, 0);
    apb(1'h1, ppbr_pkg::IDX_UL_ENABLE, 32'h1);
    run(1'h0, 8'h00, 4, 0);
    rchk(ppbr_pkg::IDX_STATUS, 32'h1, 32'h1);
    // a frozen clock enable must stall the access until it returns
    fork
      apb(1'h0, ppbr_pkg::IDX_ACTIVATE, 32'h0);
      begin
        ce <= 1'h0;
        repeat (4) @(posedge pclk);
        check({31'h0, pready}, 32'h0);
        ce <= 1'h1;
      end
    join
    check(r, 32'h1);
    results();
  end
endmodule
bind ppbr_top ppbr_monitor i_mon (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .dev_connect, .dev_ds_lock, .dev_par_lock, .rd_req, .rd_idx,
  .rd_ack, .wr_req, .wr_ack);
